//--- design/wdt_core.sv
// watchdog timer core with apb register slave
// Functional notes
// R1: 8-bit count increments on each tick
// R2: count overflow triggers timeout action
// R3: key 0x55 then 0xAA clears count
// R4: other key values change nothing
// R5: non-0xAA after 0x55 cancels sequence
// R6: key register reads return control register
// R7: bit7 reset flag, write one clears
// R8: external reset low forces flag zero
// R9: flag set after delayed pulse end
// R10: external reset low leaves flag zero
// R11: bit6 disable, resets to enabled
// R12: disable changes only while unlock set
// R13: bad check bits trigger immediate timeout
// R14: check bits always read zero
// R15: prescale divides tick by 512 times factor
// R16: writes only under protected write permit
// R17: external reset outlasts watchdog pulse
// R18: reset mode pulses reset low 512 cycles
// R19: irq mode pulses irq low 512 cycles
// R20: unlock cleared by one stays cleared
// R21: leaving irq mode during irq resets
// R22: reset clears count, key, prescaler
// R23: disabled watchdog neither counts nor fires
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module wdt_core #(
	parameter int FLAG_DELAY = wdt_pkg::FLAG_DELAY_SYS_CYC,
	parameter int PULSE_LEN  = wdt_pkg::PULSE_CYCLES,
	parameter int BASE_DIV   = wdt_pkg::BASE_DIVIDE
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        protected_write_permit,
	input  wire logic        ext_reset_n,
	output logic             wd_reset_out_n,
	output logic             wd_irq_out_n
);
	localparam int PW = $clog2(PULSE_LEN + 1);

	typedef struct packed {
		logic [7:0]          count;
		logic                armed;
		logic                flag;
		logic                dis;
		logic [2:0]          ps;
		logic                unlock;
		logic                irq_mode;
		logic                irq_s1;
		logic                irq_s2;
		wdt_pkg::wdt_pulse_t mode;
		logic [PW-1:0]       pcnt;
		logic                rst_n;
		logic                irq_n;
		logic [31:0]         rdata;
		logic                ready;
		logic                err;
	} wdt_core_st_t;

	wdt_core_st_t s_reg;
	wdt_core_st_t s_next;

	logic       tick;
	logic       flag_set;
	logic       wr_acc;
	logic       wr_key;
	logic       wr_ctrl;
	logic       wr_sys;
	logic       timeout;
	logic       chk_fault;
	logic       key_clear;
	logic [7:0] ctrl_image;
	logic [7:0] wkey;

	// tick source and delayed flag setter
	wdt_tick_gen #(
		.DIV          (BASE_DIV)
	) u_tick (
		.ref_clk      (ref_clk),
		.srst         (srst),
		.prescale_sel (s_reg.ps),
		.tick         (tick)
	);

	wdt_flag_delay #(
		.DELAY        (FLAG_DELAY)
	) u_flag (
		.ref_clk      (ref_clk),
		.srst         (srst),
		.rst_out_n    (s_reg.rst_n),
		.ext_reset_n  (ext_reset_n),
		.flag_set     (flag_set)
	);

	// write strobes, committed at the apb access edge under permit
	assign wr_acc  = psel && penable && pwrite && s_reg.ready && protected_write_permit; // R16
	assign wr_key  = wr_acc && (paddr == wdt_pkg::ADDR_KEY);
	assign wr_ctrl = wr_acc && (paddr == wdt_pkg::ADDR_CONTROL);
	assign wr_sys  = wr_acc && (paddr == wdt_pkg::ADDR_SYSCTL);
	assign wkey    = pwdata[7:0];

	// control read image, check bits forced to zero
	assign ctrl_image = {s_reg.flag, s_reg.dis, 3'h0, s_reg.ps}; // R14

	// events that clear the count or start a timeout pulse
	assign key_clear = wr_key && s_reg.armed && (wkey == wdt_pkg::KEY_FIRE); // R3
	assign timeout   = !s_reg.dis && tick && (s_reg.count == 8'hff); // R2 R23
	assign chk_fault = wr_ctrl && !s_reg.dis
		&& (pwdata[wdt_pkg::CTRL_CHK_LSB +: 3] != wdt_pkg::CHK_GOOD); // R13

	// next-state logic for registers, counter and pulse
	always_comb begin
		s_next        = s_reg;
		s_next.irq_s1 = s_reg.irq_n;
		s_next.irq_s2 = s_reg.irq_s1;

		// count and key sequence
		if (key_clear) begin
			s_next.count = 8'h00; // R3
		end else if (!s_reg.dis && tick) begin
			s_next.count = s_reg.count + 8'h01; // R1 R23
		end
		if (wr_key) begin
			if (wkey == wdt_pkg::KEY_ARM) begin
				s_next.armed = 1'b1;
			end else begin
				s_next.armed = 1'b0; // R4 R5
			end
		end

		// control register write
		if (wr_ctrl) begin
			s_next.ps = pwdata[wdt_pkg::CTRL_PS_LSB +: 3]; // R15
			if (s_reg.unlock) begin
				s_next.dis = pwdata[wdt_pkg::CTRL_DIS_BIT]; // R12
			end
			if (pwdata[wdt_pkg::CTRL_FLAG_BIT]) begin
				s_next.flag = 1'b0; // R7
			end
		end
		if (flag_set) begin
			s_next.flag = 1'b1; // R9
		end
		if (!ext_reset_n) begin
			s_next.flag = 1'b0; // R8 R10
		end

		// system control status write
		if (wr_sys) begin
			s_next.irq_mode = pwdata[wdt_pkg::SYS_IRQMODE_BIT];
			if (pwdata[wdt_pkg::SYS_UNLOCK_BIT]) begin
				s_next.unlock = 1'b0; // R20
			end
		end

		// timeout pulse sequencer
		case (s_reg.mode)
			wdt_pkg::PLS_IDLE: begin
				if (timeout || chk_fault) begin
					s_next.pcnt = '0;
					if (s_reg.irq_mode) begin
						s_next.mode  = wdt_pkg::PLS_IRQ;
						s_next.irq_n = 1'b0; // R19
					end else begin
						s_next.mode  = wdt_pkg::PLS_RESET;
						s_next.rst_n = 1'b0; // R2 R18
					end
				end
			end
			wdt_pkg::PLS_RESET: begin
				s_next.pcnt = s_reg.pcnt + PW'(1);
				if (s_reg.pcnt == PW'(PULSE_LEN - 1)) begin
					s_next.mode  = wdt_pkg::PLS_IDLE;
					s_next.rst_n = 1'b1; // R18
				end
			end
			wdt_pkg::PLS_IRQ: begin
				s_next.pcnt = s_reg.pcnt + PW'(1);
				if (!s_reg.irq_mode) begin
					s_next.mode  = wdt_pkg::PLS_RESET; // R21
					s_next.pcnt  = '0;
					s_next.irq_n = 1'b1;
					s_next.rst_n = 1'b0;
				end else if (s_reg.pcnt == PW'(PULSE_LEN - 1)) begin
					s_next.mode  = wdt_pkg::PLS_IDLE;
					s_next.irq_n = 1'b1; // R19
				end
			end
			default: begin
				s_next.mode  = wdt_pkg::PLS_IDLE;
				s_next.rst_n = 1'b1;
				s_next.irq_n = 1'b1;
			end
		endcase

		// apb: capture read data in setup, answer in the access cycle
		s_next.ready = 1'b0;
		s_next.err   = 1'b0;
		if (psel && !penable) begin
			s_next.ready = 1'b1;
			s_next.rdata = 32'h0;
			case (paddr)
				wdt_pkg::ADDR_COUNT:   s_next.rdata = {24'h0, s_reg.count};
				wdt_pkg::ADDR_KEY:     s_next.rdata = {24'h0, ctrl_image}; // R6
				wdt_pkg::ADDR_CONTROL: s_next.rdata = {24'h0, ctrl_image}; // R14
				wdt_pkg::ADDR_SYSCTL:  s_next.rdata = {29'h0, s_reg.irq_s2, s_reg.irq_mode, s_reg.unlock};
				default:               s_next.err   = 1'b1;
			endcase
		end
	end

	// state register; R11 R22
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_reg          <= '0;
			s_reg.dis      <= wdt_pkg::DIS_RESET;
			s_reg.ps       <= wdt_pkg::PS_RESET;
			s_reg.unlock   <= wdt_pkg::UNLOCK_RESET;
			s_reg.irq_mode <= wdt_pkg::IRQMODE_RESET;
			s_reg.irq_s1   <= 1'b1;
			s_reg.irq_s2   <= 1'b1;
			s_reg.mode     <= wdt_pkg::PLS_IDLE;
			s_reg.rst_n    <= 1'b1;
			s_reg.irq_n    <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata         = s_reg.rdata;
	assign pready         = s_reg.ready;
	assign pslverr        = s_reg.err;
	assign wd_reset_out_n = s_reg.rst_n;
	assign wd_irq_out_n   = s_reg.irq_n;

	// length of the current low pulse, for checking only
	logic [15:0] low_len;
	always_ff @(posedge ref_clk) begin
		if (srst || s_reg.rst_n) begin
			low_len <= 16'h0000;
		end else begin
			low_len <= low_len + 16'h0001;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence s_arm;
		wr_key && (wkey == wdt_pkg::KEY_ARM);
	endsequence
	// key service steps; the fire step only counts while the sequence is armed
	sequence s_fire;
		wr_key && s_reg.armed && (wkey == wdt_pkg::KEY_FIRE);
	endsequence

	a_count_step: assert property (tick && !s_reg.dis && !key_clear |=> s_reg.count == $past(s_reg.count) + 8'h01) // R1
		else $error("count did not step on tick");
	a_overflow_fire: assert property (timeout && s_reg.mode == wdt_pkg::PLS_IDLE && !s_reg.irq_mode // R2
		|=> !wd_reset_out_n)
		else $error("overflow did not start reset");
	a_key_arm: assert property (s_arm |=> s_reg.armed) // R3
		else $error("arm key did not arm");
	a_key_clear: assert property (s_arm ##[1:20] s_fire |=> s_reg.count == 8'h00) // R3
		else $error("key pair did not clear count");
	a_odd_key: assert property (wr_key && !s_reg.armed && wkey != wdt_pkg::KEY_ARM |=> !s_reg.armed) // R4
		else $error("odd key armed sequence");
	a_key_cancel: assert property (wr_key && s_reg.armed && wkey != wdt_pkg::KEY_FIRE // R5
		&& wkey != wdt_pkg::KEY_ARM |=> !s_reg.armed)
		else $error("sequence not cancelled");
	a_key_read: assert property (psel && !penable && paddr == wdt_pkg::ADDR_KEY // R6
		|=> prdata[7:0] == $past(ctrl_image))
		else $error("key read not control image");
	a_flag_forced: assert property (!ext_reset_n |=> !s_reg.flag) // R8
		else $error("flag not forced low");
	a_dis_locked: assert property (wr_ctrl && !s_reg.unlock |=> s_reg.dis == $past(s_reg.dis)) // R12
		else $error("disable changed while locked");
	a_chk_zero: assert property (psel && !penable && paddr == wdt_pkg::ADDR_CONTROL |=> prdata[5:3] == 3'h0) // R14
		else $error("check bits read nonzero");
	a_rst_len: assert property ($rose(wd_reset_out_n) |-> $past(low_len) == 16'(PULSE_LEN - 1)) // R18
		else $error("reset pulse length wrong");
	a_irq_held: assert property ($fell(wd_irq_out_n) |-> (!wd_irq_out_n || !s_reg.irq_mode)[*8]) // R19
		else $error("irq pulse too short");
	a_unlock_stays: assert property (!s_reg.unlock |=> !s_reg.unlock) // R20
		else $error("unlock came back");
	a_irq_to_rst: assert property (!wd_irq_out_n && !s_reg.irq_mode |=> !wd_reset_out_n) // R21
		else $error("no reset on leaving irq mode");
	a_dis_quiet: assert property (s_reg.dis && !key_clear |=> s_reg.count == $past(s_reg.count)) // R23
		else $error("count moved while disabled");

	// key writes that are neither key value leave the count alone
	a_odd_count: assert property (wr_key && wkey != wdt_pkg::KEY_ARM && wkey != wdt_pkg::KEY_FIRE && !tick // R4
		|=> s_reg.count == $past(s_reg.count))
		else $error("odd key moved count");

	// reset flag: set only by the delayed setter, held until cleared by a one or by ext_reset_n low
	a_flag_set: assert property (flag_set && ext_reset_n |=> s_reg.flag) // R9
		else $error("flag not set after pulse");
	a_flag_cause: assert property (!s_reg.flag && !flag_set |=> !s_reg.flag) // R10
		else $error("flag set without cause");
	a_flag_latched: assert property (s_reg.flag && ext_reset_n && !(wr_ctrl && pwdata[wdt_pkg::CTRL_FLAG_BIT]) // R7
		|=> s_reg.flag)
		else $error("flag dropped without clear");
	a_flag_clear: assert property (wr_ctrl && pwdata[wdt_pkg::CTRL_FLAG_BIT] && !flag_set |=> !s_reg.flag) // R7
		else $error("flag not cleared by one");

	// a bad check pattern fires like an overflow, in the selected mode
	a_chk_fire: assert property (chk_fault && s_reg.mode == wdt_pkg::PLS_IDLE && !s_reg.irq_mode // R13
		|=> !wd_reset_out_n)
		else $error("bad check bits did not fire");
	a_irq_fire: assert property ((timeout || chk_fault) && s_reg.mode == wdt_pkg::PLS_IDLE && s_reg.irq_mode // R19
		|=> !wd_irq_out_n && wd_reset_out_n)
		else $error("irq mode did not raise irq");

	// pulse shape: once low, the reset output stays low for at least 8 cycles
	a_rst_held: assert property ($fell(wd_reset_out_n) |-> (!wd_reset_out_n)[*8]) // R18
		else $error("reset pulse too short");

	// writes without the permit change no state
	a_permit_gate: assert property (psel && penable && pwrite && !protected_write_permit // R16
		|=> s_reg.ps == $past(s_reg.ps) && s_reg.dis == $past(s_reg.dis) && s_reg.armed == $past(s_reg.armed))
		else $error("write taken without permit");

	// reset leaves an enabled watchdog with a clear count and no armed key
	a_reset_clear: assert property (@(posedge ref_clk) disable iff (1'b0) srst // R22
		|=> s_reg.count == 8'h00 && !s_reg.armed)
		else $error("reset did not clear count");
	a_reset_enable: assert property (@(posedge ref_clk) disable iff (1'b0) srst |=> !s_reg.dis) // R11
		else $error("reset left watchdog disabled");

endmodule : wdt_core
`default_nettype wire

//--- design/wdt_flag_delay.sv
// delays the end of a watchdog reset pulse before it may set the flag
`timescale 1ns/1ns
`default_nettype none
module wdt_flag_delay #(
	parameter int DELAY = wdt_pkg::FLAG_DELAY_SYS_CYC
) (
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic rst_out_n,
	input  wire logic ext_reset_n,
	output logic      flag_set
);
	localparam int CW = $clog2(DELAY + 1);

	typedef struct packed {
		logic          prev;
		logic          busy;
		logic [CW-1:0] cnt;
		logic          set;
	} wdt_dly_st_t;

	wdt_dly_st_t s_reg;
	wdt_dly_st_t s_next;

	// rising edge starts the delay, expiry samples the external reset line
	always_comb begin
		s_next      = s_reg;
		s_next.prev = rst_out_n;
		s_next.set  = 1'b0;
		if (rst_out_n && !s_reg.prev) begin // R9
			s_next.busy = 1'b1;
			s_next.cnt  = '0;
		end else if (s_reg.busy) begin
			s_next.cnt = s_reg.cnt + CW'(1);
			if (s_reg.cnt == CW'(DELAY - 1)) begin
				s_next.busy = 1'b0;
				s_next.set  = ext_reset_n; // R9 R10
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_reg      <= '0;
			s_reg.prev <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign flag_set = s_reg.set;
endmodule : wdt_flag_delay
`default_nettype wire

//--- design/wdt_pkg.sv
// constants and types shared by the watchdog timer core files
package wdt_pkg;

	// register byte offsets on the apb bus
	localparam logic [11:0] ADDR_COUNT   = 12'h000;
	localparam logic [11:0] ADDR_KEY     = 12'h004;
	localparam logic [11:0] ADDR_CONTROL = 12'h008;
	localparam logic [11:0] ADDR_SYSCTL  = 12'h00c;

	// service key values
	localparam logic [7:0] KEY_ARM  = 8'h55;
	localparam logic [7:0] KEY_FIRE = 8'haa;

	// control register fields
	localparam int          CTRL_FLAG_BIT = 7;
	localparam int          CTRL_DIS_BIT  = 6;
	localparam int          CTRL_CHK_LSB  = 3;
	localparam int          CTRL_PS_LSB   = 0;
	localparam logic [2:0]  CHK_GOOD      = 3'h5;
	localparam logic [2:0]  PS_RESET      = 3'h0;
	localparam logic        DIS_RESET     = 1'b0;

	// system control status fields
	localparam int          SYS_UNLOCK_BIT  = 0;
	localparam int          SYS_IRQMODE_BIT = 1;
	localparam int          SYS_IRQSTAT_BIT = 2;
	localparam logic        UNLOCK_RESET    = 1'b1;
	localparam logic        IRQMODE_RESET   = 1'b0;

	// timing: oscillator and system clock are both ref_clk (100 ns)
	localparam int CLK_PERIOD_NS       = 100;
	localparam int BASE_DIVIDE         = 512;
	localparam int PULSE_OSC_CYCLES    = 512;
	localparam int FLAG_DELAY_SYS_CYC  = 8192;
	localparam int OSC_PER_REF         = 1;
	localparam int PULSE_CYCLES        = PULSE_OSC_CYCLES * OSC_PER_REF;

	// timeout pulse state, gray on idle -> reset and on irq -> reset; idle -> irq changes both bits
	typedef enum logic [1:0] {
		PLS_IDLE  = 2'h0,
		PLS_RESET = 2'h1,
		PLS_IRQ   = 2'h3
	} wdt_pulse_t;

endpackage : wdt_pkg

//--- design/wdt_tick_gen.sv
// watchdog tick generator: fixed divide then selectable prescale
`timescale 1ns/1ns
`default_nettype none
module wdt_tick_gen #(
	parameter int DIV = wdt_pkg::BASE_DIVIDE
) (
	input  wire logic       ref_clk,
	input  wire logic       srst,
	input  wire logic [2:0] prescale_sel,
	output logic            tick
);
	localparam int BW = $clog2(DIV);

	typedef struct packed {
		logic [BW-1:0] base;
		logic [5:0]    pre;
		logic          tick;
	} wdt_tick_st_t;

	wdt_tick_st_t s_reg;
	wdt_tick_st_t s_next;
	logic [5:0]   mask;

	// prescale code to low-bit mask of the second stage
	always_comb begin
		case (prescale_sel)
			3'h2:    mask = 6'h01;
			3'h3:    mask = 6'h03;
			3'h4:    mask = 6'h07;
			3'h5:    mask = 6'h0f;
			3'h6:    mask = 6'h1f;
			3'h7:    mask = 6'h3f;
			default: mask = 6'h00; // codes 0 and 1 divide by one
		endcase
	end

	// divide chain, one tick per prescaled period
	always_comb begin
		s_next      = s_reg;
		s_next.tick = 1'b0;
		if (s_reg.base == BW'(DIV - 1)) begin // R15
			s_next.base = '0;
			s_next.pre  = s_reg.pre + 6'h01;
			s_next.tick = ((s_reg.pre & mask) == mask);
		end else begin
			s_next.base = s_reg.base + BW'(1);
		end
	end

	// R22
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tick = s_reg.tick;
endmodule : wdt_tick_gen
`default_nettype wire

//--- test/watchdog_timer_core_test.sv
// self-checking testbench for the watchdog timer core
`timescale 1ns/1ns
`default_nettype none
module watchdog_timer_core_test;
	logic        ref_clk;
	logic        srst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        permit;
	logic        ext_reset_n;
	logic        wd_reset_out_n;
	logic        wd_irq_out_n;
	logic [31:0] r;
	logic [31:0] c;
	logic        serr;
	int          rst_cycles = 0;
	int          rst_mark;
	int          err_total;
	int          samples_checked;
	int          n;

	// short counts keep the run brief: tick every 4 cycles, pulse 8, flag delay 16
	wdt_core #(.FLAG_DELAY(16), .PULSE_LEN(8), .BASE_DIV(4)) i_wdt_core (
		.ref_clk                (ref_clk),
		.srst                   (srst),
		.psel                   (psel),
		.penable                (penable),
		.pwrite                 (pwrite),
		.paddr                  (paddr),
		.pwdata                 (pwdata),
		.prdata                 (prdata),
		.pready                 (pready),
		.pslverr                (pslverr),
		.protected_write_permit (permit),
		.ext_reset_n            (ext_reset_n),
		.wd_reset_out_n         (wd_reset_out_n),
		.wd_irq_out_n           (wd_irq_out_n)
	);

	// clock at 100 ns period
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// counts cycles with the reset output low; tests compare against a mark
	always @(posedge ref_clk) begin
		if (wd_reset_out_n === 1'b0)
			rst_cycles <= rst_cycles + 1;
	end

	task results;
		$display("compared %0d values, %0d mismatches", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	task fail(input string m);
		err_total++;
		$display("wrong value at %0t: %s", $time, m);
		results();
	endtask : fail

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk

	// one apb transfer; access held until the edge that samples pready high, data taken there
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1)
			fail("no apb answer");
		r       = prdata;
		serr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : cyc

	// waits for a low pulse and returns its length in cycles
	task wait_low(input logic irq, output int len);
		int k;
		len = 0;
		@(negedge ref_clk);
		for (k = 0; k < 3000 && (irq ? wd_irq_out_n : wd_reset_out_n) !== 1'b0; k++) begin
			@(negedge ref_clk);
		end
		if (k == 3000)
			fail("no timeout pulse");
		while ((irq ? wd_irq_out_n : wd_reset_out_n) === 1'b0 && len < 1000) begin
			@(negedge ref_clk);
			len++;
		end
	endtask : wait_low

	// main sequence
	initial begin
		srst            = 1'b1;
		psel            = 1'b0;
		penable         = 1'b0;
		pwrite          = 1'b0;
		paddr           = 12'h000;
		pwdata          = 32'h0;
		permit          = 1'b1;
		ext_reset_n     = 1'b1;
		rst_mark        = 0;
		err_total       = 0;
		samples_checked = 0;
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		rd(wdt_pkg::ADDR_COUNT);
		chk({31'h0, r < 2}, 32'h1, "count after reset");
		rd(wdt_pkg::ADDR_CONTROL);
		chk(r, 32'h0, "control after reset");
		rd(wdt_pkg::ADDR_SYSCTL);
		chk(r, 32'h5, "status after reset");
		rd(12'h010);
		chk({31'h0, serr}, 32'h1, "unmapped error");
		wr(wdt_pkg::ADDR_CONTROL, 32'h2f);
		rd(wdt_pkg::ADDR_CONTROL);
		chk(r, 32'h07, "check bits read zero");
		rd(wdt_pkg::ADDR_KEY);
		chk(r, 32'h07, "key read shows control");
		$display("test registers done");
		wr(wdt_pkg::ADDR_CONTROL, 32'h28);
		cyc(120);
		wr(wdt_pkg::ADDR_KEY, 32'h12);
		wr(wdt_pkg::ADDR_KEY, 32'haa);
		rd(wdt_pkg::ADDR_COUNT);
		chk({31'h0, r >= 16}, 32'h1, "other key clears nothing");
		wr(wdt_pkg::ADDR_KEY, 32'h55);
		wr(wdt_pkg::ADDR_KEY, 32'h12);
		wr(wdt_pkg::ADDR_KEY, 32'haa);
		rd(wdt_pkg::ADDR_COUNT);
		chk({31'h0, r >= 16}, 32'h1, "cancelled sequence");
		wr(wdt_pkg::ADDR_KEY, 32'h55);
		wr(wdt_pkg::ADDR_KEY, 32'haa);
		rd(wdt_pkg::ADDR_COUNT);
		chk({31'h0, r < 4}, 32'h1, "key pair clears count");
		permit <= 1'b0;
		cyc(60);
		wr(wdt_pkg::ADDR_KEY, 32'h55);
		wr(wdt_pkg::ADDR_KEY, 32'haa);
		rd(wdt_pkg::ADDR_COUNT);
		chk({31'h0, r >= 12}, 32'h1, "keys ignored without permit");
		permit <= 1'b1;
		wr(wdt_pkg::ADDR_CONTROL, 32'h2b);
		wr(wdt_pkg::ADDR_KEY, 32'h55);
		wr(wdt_pkg::ADDR_KEY, 32'haa);
		cyc(160);
		rd(wdt_pkg::ADDR_COUNT);
		chk({31'h0, r >= 9 && r <= 11}, 32'h1, "prescale by four");
		wr(wdt_pkg::ADDR_CONTROL, 32'h28);
		$display("test service keys done");
		wait_low(1'b0, n);
		chk(32'(n), 32'h8, "overflow reset pulse");
		cyc(30);
		rd(wdt_pkg::ADDR_CONTROL);
		chk(r, 32'h80, "flag after timeout");
		wr(wdt_pkg::ADDR_CONTROL, 32'h28);
		rd(wdt_pkg::ADDR_CONTROL);
		chk(r, 32'h80, "flag write zero ignored");
		wr(wdt_pkg::ADDR_CONTROL, 32'ha8);
		rd(wdt_pkg::ADDR_CONTROL);
		chk(r, 32'h00, "flag write one clears");
		$display("test overflow done");
		wr(wdt_pkg::ADDR_CONTROL, 32'h00);
		wait_low(1'b0, n);
		chk(32'(n), 32'h8, "bad check bits pulse");
		cyc(30);
		ext_reset_n <= 1'b0;
		rd(wdt_pkg::ADDR_CONTROL);
		chk(r, 32'h00, "flag forced low");
		wr(wdt_pkg::ADDR_CONTROL, 32'h00);
		wait_low(1'b0, n);
		cyc(30);
		ext_reset_n <= 1'b1;
		rd(wdt_pkg::ADDR_CONTROL);
		chk(r, 32'h00, "flag stays low");
		$display("test check bits done");
		wr(wdt_pkg::ADDR_SYSCTL, 32'h2);
		rst_mark = rst_cycles;
		wr(wdt_pkg::ADDR_CONTROL, 32'h00);
		wait_low(1'b1, n);
		chk(32'(n), 32'h8, "irq pulse length");
		chk(32'(rst_cycles - rst_mark), 32'h0, "no reset in irq mode");
		wr(wdt_pkg::ADDR_CONTROL, 32'h00);
		wr(wdt_pkg::ADDR_SYSCTL, 32'h0);
		wait_low(1'b0, n);
		chk(32'(n), 32'h8, "reset on leaving irq mode");
		cyc(30);
		$display("test irq mode done");
		wr(wdt_pkg::ADDR_CONTROL, 32'he8);
		rd(wdt_pkg::ADDR_COUNT);
		c = r;
		rst_mark = rst_cycles;
		wr(wdt_pkg::ADDR_CONTROL, 32'h40);
		cyc(40);
		rd(wdt_pkg::ADDR_COUNT);
		chk(r, c, "count frozen when disabled");
		chk(32'(rst_cycles - rst_mark), 32'h0, "no fault when disabled");
		wr(wdt_pkg::ADDR_SYSCTL, 32'h1);
		wr(wdt_pkg::ADDR_SYSCTL, 32'h0);
		rd(wdt_pkg::ADDR_SYSCTL);
		chk(r, 32'h4, "unlock stays cleared");
		wr(wdt_pkg::ADDR_CONTROL, 32'h28);
		rd(wdt_pkg::ADDR_CONTROL);
		chk(r, 32'h40, "disable locked");
		$display("test disable done");
		results();
	end
endmodule : watchdog_timer_core_test
`default_nettype wire
